// >>> dowf_warning_flags.sv
// Purpose: Threshold monitor raising drive warning flags for output terminals
// Assumes: Measured quantities arrive on core_clk from the control loop
// Notes: Flags are advisory only; nothing here trips or limits the drive
// Function
// - Overload flag rises when motor current reaches the overload warning level.
// - Flags only signal; they never trip the drive or limit current.
// - Overload mode 00 checks all ramp states, 01 constant speed only; default 01.
// - Overload level zero disables the flag; second motor has its own level.
// - Arrival flag one uses an acceleration threshold, 0.00 to 400.00 Hz.
// - Arrival flag one uses a separate deceleration threshold, same range.
// - A second threshold pair drives arrival flag two.
// - Deviation flag rises when setpoint minus feedback magnitude exceeds the limit.
// - Feedback above upper limit switches the second-stage output off.
// - Feedback below lower limit switches the second-stage output on.
// - Torque selection 00 detects over-torque, 01 under-torque; default 00.
// - Four torque levels by quadrant, 0 to 200 %, default 100.
// - Torque mode picks all ramp states or constant speed only; default 01.
// - Torque flag is meaningful only under sensorless vector control.
// - Zero-speed flag rises when output frequency is below the zero-speed level.
// - Zero-speed flag can be routed to either terminal or the relay.
// - Heat-sink flag rises when temperature exceeds the warning level.
// - Thermal warning level 0 to 100 %, default 90, zero disables.
// - Pulse train input is scaled by 0.01 to 99.99, default 1.00.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module dowf_warning_flags #(
  parameter int CTRL_CYCLES = dowf_pkg::CTRL_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] motorCurrent,
  input wire logic [15:0] outFreq,
  input wire logic rampAccel,
  input wire logic rampDecel,
  input wire logic motorTwoActive,
  input wire logic [15:0] pidSetpoint,
  input wire logic [15:0] pidFeedback,
  input wire logic signed [15:0] torqueEst,
  input wire logic runReverse,
  input wire logic regenActive,
  input wire logic vectorCtrlActive,
  input wire logic [15:0] thermalLoad,
  input wire logic [15:0] heatsinkTemp,
  input wire logic pulseTrainPin,
  output logic overloadWarningFlag,
  output logic arrivalFlagOne,
  output logic arrivalFlagTwo,
  output logic pidDeviationFlag,
  output logic pidSecondStage,
  output logic torqueThresholdFlag,
  output logic zeroSpeedFlag,
  output logic thermalWarnFlag,
  output logic heatsinkHotFlag,
  output logic [2:0] termOut,
  output logic pulseOut
);

  localparam int CNT_W = (CTRL_CYCLES > 1) ? $clog2(CTRL_CYCLES) : 1;

  if (CTRL_CYCLES < 2 || CTRL_CYCLES > 65536) begin : g_bad_cycles
    $error("CTRL_CYCLES out of range");
  end

  logic [15:0] cfgQ [dowf_pkg::NUM_REGS];
  logic [dowf_pkg::NUM_FLAGS-1:0] flagsQ;
  logic olQ, devQ, pid2Q, tqQ, zeroQ, thermQ, hsQ;

  // Control cycle enable
  logic [CNT_W-1:0] ctrlCntQ;
  logic ctrlTick;

  always_ff @(posedge core_clk) begin
    if (rst || ctrlCntQ == CNT_W'(CTRL_CYCLES - 1)) begin
      ctrlCntQ <= '0;
    end else begin
      ctrlCntQ <= ctrlCntQ + 1'b1;
    end
  end

  assign ctrlTick = (ctrlCntQ == CNT_W'(CTRL_CYCLES - 1));

  // AXI4-Lite write path: address and data captured independently
  logic awHeldQ;
  logic wHeldQ;
  logic [31:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic wrHit;
  logic [4:0] wrIdx;

  assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
  assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
  assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
  assign wrIdx = awAddrQ[6:2];

  always_comb begin
    if (awAddrQ[31:7] != 25'h0 || awAddrQ[1:0] != 2'h0) begin
      wrHit = 1'b0;
    end else if (int'(wrIdx) >= dowf_pkg::NUM_REGS) begin
      wrHit = 1'b0;
    end else if (wrIdx == dowf_pkg::OFS_STATUS[6:2]) begin
      wrHit = 1'b0;
    end else begin
      wrHit = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeldQ <= 1'b0;
      awAddrQ <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeldQ <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wHeldQ <= 1'b0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeldQ <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dowf_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? dowf_pkg::RESP_OKAY : dowf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Settings; only the low half-word exists, upper lanes are ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < dowf_pkg::NUM_REGS; i++) begin
        cfgQ[i] <= dowf_pkg::cfg_reset(7'(i * 4));
      end
    end else if (doWrite && wrHit) begin
      if (wStrbQ[0]) begin
        cfgQ[wrIdx][7:0] <= wDataQ[7:0];
      end
      if (wStrbQ[1]) begin
        cfgQ[wrIdx][15:8] <= wDataQ[15:8];
      end
    end
  end

  // AXI4-Lite read path
  logic [4:0] rdIdx;
  logic [31:0] rdData;
  logic rdHit;

  assign s_axi_arready = !s_axi_rvalid;
  assign rdIdx = s_axi_araddr[6:2];

  always_comb begin
    rdData = 32'h0;
    rdHit = 1'b1;
    if (s_axi_araddr[31:7] != 25'h0 || s_axi_araddr[1:0] != 2'h0) begin
      rdHit = 1'b0;
    end else if (int'(rdIdx) >= dowf_pkg::NUM_REGS) begin
      rdHit = 1'b0;
    end else if (rdIdx == dowf_pkg::OFS_STATUS[6:2]) begin
      rdData = 32'(flagsQ);
    end else begin
      rdData = {16'h0, cfgQ[rdIdx]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dowf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdHit ? dowf_pkg::RESP_OKAY : dowf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Setting fields
  logic [15:0] ctrlReg;
  logic [1:0] olMode;
  logic [1:0] tqMode;
  logic [1:0] tqDir;
  logic [15:0] olLevel;
  logic constSpeed;
  logic [15:0] tqLevel;
  logic [16:0] tqMag;
  logic [16:0] pidErr;

  assign ctrlReg = cfgQ[dowf_pkg::OFS_CTRL[6:2]];
  assign olMode = ctrlReg[dowf_pkg::OL_MODE_LSB +: 2];
  assign tqMode = ctrlReg[dowf_pkg::TQ_MODE_LSB +: 2];
  assign tqDir = ctrlReg[dowf_pkg::TQ_DIR_LSB +: 2];
  assign constSpeed = !rampAccel && !rampDecel;
  assign olLevel = motorTwoActive ? cfgQ[dowf_pkg::OFS_OL_LEVEL_TWO[6:2]] : cfgQ[dowf_pkg::OFS_OL_LEVEL[6:2]];
  assign pidErr = (pidSetpoint >= pidFeedback) ? 17'(pidSetpoint - pidFeedback) : 17'(pidFeedback - pidSetpoint);
  assign tqMag = torqueEst[15] ? 17'(-{torqueEst[15], torqueEst}) : 17'({torqueEst[15], torqueEst});

  always_comb begin
    if (!runReverse && !regenActive) begin
      tqLevel = cfgQ[dowf_pkg::OFS_TQ_FWD_POWER[6:2]];
    end else if (runReverse && regenActive) begin
      tqLevel = cfgQ[dowf_pkg::OFS_TQ_REV_REGEN[6:2]];
    end else if (runReverse) begin
      tqLevel = cfgQ[dowf_pkg::OFS_TQ_REV_POWER[6:2]];
    end else begin
      tqLevel = cfgQ[dowf_pkg::OFS_TQ_FWD_REGEN[6:2]];
    end
  end

  // Flags only update on the control tick; warnings feed outputs, never trip logic
  always_ff @(posedge core_clk) begin
    if (rst) begin
      olQ <= 1'b0;
    end else if (ctrlTick) begin
      olQ <= (olLevel != 16'h0) && (motorCurrent >= olLevel)
        && (olMode == dowf_pkg::MODE_ANY_RAMP || constSpeed);
    end
  end

  // Arrival flags hold their level at constant speed, giving edge timing per ramp
  logic arrivalQ [2];
  logic [15:0] accelThr [2];
  logic [15:0] decelThr [2];

  assign accelThr[0] = cfgQ[dowf_pkg::OFS_ACCEL_ARR[6:2]];
  assign decelThr[0] = cfgQ[dowf_pkg::OFS_DECEL_ARR[6:2]];
  assign accelThr[1] = cfgQ[dowf_pkg::OFS_ACCEL_ARR_TWO[6:2]];
  assign decelThr[1] = cfgQ[dowf_pkg::OFS_DECEL_ARR_TWO[6:2]];

  for (genvar k = 0; k < 2; k++) begin : g_arrival
    always_ff @(posedge core_clk) begin
      if (rst) begin
        arrivalQ[k] <= 1'b0;
      end else if (ctrlTick && rampAccel) begin
        arrivalQ[k] <= outFreq >= accelThr[k];
      end else if (ctrlTick && rampDecel) begin
        arrivalQ[k] <= outFreq >= decelThr[k];
      end
    end
  end

  // One process gathers the status word so each flag keeps a single driver
  always_comb begin
    flagsQ = '0;
    flagsQ[dowf_pkg::FLAG_OL] = olQ;
    flagsQ[dowf_pkg::FLAG_ARR1] = arrivalQ[0];
    flagsQ[dowf_pkg::FLAG_ARR2] = arrivalQ[1];
    flagsQ[dowf_pkg::FLAG_PID_DEV] = devQ;
    flagsQ[dowf_pkg::FLAG_PID_SECOND] = pid2Q;
    flagsQ[dowf_pkg::FLAG_TORQUE] = tqQ;
    flagsQ[dowf_pkg::FLAG_ZERO] = zeroQ;
    flagsQ[dowf_pkg::FLAG_THERMAL] = thermQ;
    flagsQ[dowf_pkg::FLAG_HEATSINK] = hsQ;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      devQ <= 1'b0;
    end else if (ctrlTick) begin
      devQ <= pidErr > 17'(cfgQ[dowf_pkg::OFS_PID_ERR[6:2]]);
    end
  end

  // Between the limits the second stage keeps its state; off wins if limits cross
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pid2Q <= 1'b0;
    end else if (ctrlTick && pidFeedback > cfgQ[dowf_pkg::OFS_FB_UPPER[6:2]]) begin
      pid2Q <= 1'b0;
    end else if (ctrlTick && pidFeedback < cfgQ[dowf_pkg::OFS_FB_LOWER[6:2]]) begin
      pid2Q <= 1'b1;
    end
  end

  // Held low outside sensorless vector control so the output is at least defined
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tqQ <= 1'b0;
    end else if (ctrlTick) begin
      tqQ <= vectorCtrlActive
        && (tqMode == dowf_pkg::MODE_ANY_RAMP || constSpeed)
        && ((tqDir == dowf_pkg::TQ_SEL_OVER && tqMag > 17'(tqLevel))
        || (tqDir == dowf_pkg::TQ_SEL_UNDER && tqMag < 17'(tqLevel)));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zeroQ <= 1'b0;
      thermQ <= 1'b0;
      hsQ <= 1'b0;
    end else if (ctrlTick) begin
      zeroQ <= outFreq < cfgQ[dowf_pkg::OFS_ZERO_SPEED[6:2]];
      thermQ <= (cfgQ[dowf_pkg::OFS_THERMAL_WARN[6:2]] != 16'h0)
        && (thermalLoad >= cfgQ[dowf_pkg::OFS_THERMAL_WARN[6:2]]);
      hsQ <= heatsinkTemp > cfgQ[dowf_pkg::OFS_HEATSINK_WARN[6:2]];
    end
  end

  assign overloadWarningFlag = flagsQ[dowf_pkg::FLAG_OL];
  assign arrivalFlagOne = flagsQ[dowf_pkg::FLAG_ARR1];
  assign arrivalFlagTwo = flagsQ[dowf_pkg::FLAG_ARR2];
  assign pidDeviationFlag = flagsQ[dowf_pkg::FLAG_PID_DEV];
  assign pidSecondStage = flagsQ[dowf_pkg::FLAG_PID_SECOND];
  assign torqueThresholdFlag = flagsQ[dowf_pkg::FLAG_TORQUE];
  assign zeroSpeedFlag = flagsQ[dowf_pkg::FLAG_ZERO];
  assign thermalWarnFlag = flagsQ[dowf_pkg::FLAG_THERMAL];
  assign heatsinkHotFlag = flagsQ[dowf_pkg::FLAG_HEATSINK];

  // Terminal routing by function code; unknown codes drive low
  function automatic logic route_flag(input logic [7:0] code, input logic [dowf_pkg::NUM_FLAGS-1:0] f);
    logic r;
    r = 1'b0;
    case (code)
      dowf_pkg::FC_OVERLOAD: r = f[dowf_pkg::FLAG_OL];
      dowf_pkg::FC_ARRIVAL_ONE: r = f[dowf_pkg::FLAG_ARR1];
      dowf_pkg::FC_ARRIVAL_TWO: r = f[dowf_pkg::FLAG_ARR2];
      dowf_pkg::FC_PID_DEV: r = f[dowf_pkg::FLAG_PID_DEV];
      dowf_pkg::FC_PID_SECOND: r = f[dowf_pkg::FLAG_PID_SECOND];
      dowf_pkg::FC_TORQUE: r = f[dowf_pkg::FLAG_TORQUE];
      dowf_pkg::FC_ZERO_SPEED: r = f[dowf_pkg::FLAG_ZERO];
      dowf_pkg::FC_THERMAL: r = f[dowf_pkg::FLAG_THERMAL];
      dowf_pkg::FC_HEATSINK: r = f[dowf_pkg::FLAG_HEATSINK];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : route_flag

  for (genvar t = 0; t < 3; t++) begin : g_term
    always_ff @(posedge core_clk) begin
      if (rst) begin
        termOut[t] <= 1'b0;
      end else begin
        termOut[t] <= route_flag(cfgQ[int'(dowf_pkg::OFS_ROUTE_TERM11[6:2]) + t][7:0], flagsQ);
      end
    end
  end

  // Pulse train scaling; input rate must stay below one pulse per 2*scale cycles
  logic [2:0] pinSyncQ;
  logic [23:0] pulseAccQ;
  logic pinRise;
  logic emitPulse;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinSyncQ <= 3'h0;
    end else begin
      pinSyncQ <= {pinSyncQ[1:0], pulseTrainPin};
    end
  end

  assign pinRise = pinSyncQ[1] && !pinSyncQ[2];
  assign emitPulse = (pulseAccQ >= dowf_pkg::PULSE_UNITY) && !pulseOut;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulseAccQ <= 24'h0;
      pulseOut <= 1'b0;
    end else begin
      pulseAccQ <= pulseAccQ + (pinRise ? 24'(cfgQ[dowf_pkg::OFS_PULSE_SCALE[6:2]]) : 24'h0)
        - (emitPulse ? dowf_pkg::PULSE_UNITY : 24'h0);
      pulseOut <= emitPulse;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_ol_set;
    ctrlTick && olLevel != 16'h0 && motorCurrent >= olLevel && (olMode == dowf_pkg::MODE_ANY_RAMP || constSpeed)
      |=> overloadWarningFlag;
  endproperty
  a_ol_set: assert property (p_ol_set) else $error("overload flag missed");

  property p_ol_mode;
    ctrlTick && olMode == dowf_pkg::MODE_CONST_ONLY && !constSpeed |=> !overloadWarningFlag;
  endproperty
  a_ol_mode: assert property (p_ol_mode) else $error("overload flag set while ramping");

  property p_ol_off;
    ctrlTick && olLevel == 16'h0 |=> !overloadWarningFlag;
  endproperty
  a_ol_off: assert property (p_ol_off) else $error("overload flag set with zero level");

  property p_pid_dev;
    ctrlTick |=> pidDeviationFlag == ($past(pidErr) > 17'($past(cfgQ[dowf_pkg::OFS_PID_ERR[6:2]])));
  endproperty
  a_pid_dev: assert property (p_pid_dev) else $error("deviation flag wrong");

  property p_pid_off;
    ctrlTick && pidFeedback > cfgQ[dowf_pkg::OFS_FB_UPPER[6:2]] |=> !pidSecondStage;
  endproperty
  a_pid_off: assert property (p_pid_off) else $error("second stage not off");

  property p_pid_on;
    ctrlTick && pidFeedback < cfgQ[dowf_pkg::OFS_FB_LOWER[6:2]]
      && !(pidFeedback > cfgQ[dowf_pkg::OFS_FB_UPPER[6:2]]) |=> pidSecondStage;
  endproperty
  a_pid_on: assert property (p_pid_on) else $error("second stage not on");

  property p_tq_vector;
    ctrlTick && !vectorCtrlActive |=> !torqueThresholdFlag;
  endproperty
  a_tq_vector: assert property (p_tq_vector) else $error("torque flag outside vector control");

  property p_zero;
    ctrlTick && outFreq < cfgQ[dowf_pkg::OFS_ZERO_SPEED[6:2]] |=> zeroSpeedFlag;
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed flag missed");

  property p_heatsink;
    ctrlTick |=> heatsinkHotFlag == ($past(heatsinkTemp) > $past(cfgQ[dowf_pkg::OFS_HEATSINK_WARN[6:2]]));
  endproperty
  a_heatsink: assert property (p_heatsink) else $error("heat-sink flag wrong");

  property p_thermal_off;
    ctrlTick && cfgQ[dowf_pkg::OFS_THERMAL_WARN[6:2]] == 16'h0 |=> !thermalWarnFlag;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("thermal flag set while disabled");

  property p_hold;
    !ctrlTick |=> $stable(flagsQ);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed off the control tick");

  property p_route_zero;
    cfgQ[dowf_pkg::OFS_ROUTE_RELAY[6:2]][7:0] == dowf_pkg::FC_ZERO_SPEED |=> termOut[2] == $past(zeroSpeedFlag);
  endproperty
  a_route_zero: assert property (p_route_zero) else $error("relay does not follow zero speed");

  property p_pulse;
    pulseAccQ >= dowf_pkg::PULSE_UNITY && !pulseOut |=> pulseOut ##1 !pulseOut;
  endproperty
  a_pulse: assert property (p_pulse) else $error("scaled pulse not emitted");

  c_ol: cover property (ctrlTick ##1 overloadWarningFlag);
  c_pid_second: cover property (!pidSecondStage ##1 pidSecondStage);
  c_pulse: cover property (pinRise ##[1:20] pulseOut);
  c_write: cover property (doWrite && wrHit ##1 s_axi_bvalid);

endmodule : dowf_warning_flags

// >>> dowf_pkg.sv
// Purpose: Shared constants for the drive output warning flag block
// Assumes: 50 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: Quantities use fixed-point units noted beside each reset value
package dowf_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int CTRL_CYCLES = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map, byte offsets
  localparam int NUM_REGS = 22;
  localparam logic [6:0] OFS_CTRL = 7'h00;
  localparam logic [6:0] OFS_OL_LEVEL = 7'h04;
  localparam logic [6:0] OFS_OL_LEVEL_TWO = 7'h08;
  localparam logic [6:0] OFS_ACCEL_ARR = 7'h0c;
  localparam logic [6:0] OFS_DECEL_ARR = 7'h10;
  localparam logic [6:0] OFS_ACCEL_ARR_TWO = 7'h14;
  localparam logic [6:0] OFS_DECEL_ARR_TWO = 7'h18;
  localparam logic [6:0] OFS_PID_ERR = 7'h1c;
  localparam logic [6:0] OFS_PULSE_SCALE = 7'h20;
  localparam logic [6:0] OFS_FB_UPPER = 7'h24;
  localparam logic [6:0] OFS_FB_LOWER = 7'h28;
  localparam logic [6:0] OFS_TQ_FWD_POWER = 7'h2c;
  localparam logic [6:0] OFS_TQ_REV_REGEN = 7'h30;
  localparam logic [6:0] OFS_TQ_REV_POWER = 7'h34;
  localparam logic [6:0] OFS_TQ_FWD_REGEN = 7'h38;
  localparam logic [6:0] OFS_THERMAL_WARN = 7'h3c;
  localparam logic [6:0] OFS_ZERO_SPEED = 7'h40;
  localparam logic [6:0] OFS_HEATSINK_WARN = 7'h44;
  localparam logic [6:0] OFS_STATUS = 7'h48;
  localparam logic [6:0] OFS_ROUTE_TERM11 = 7'h4c;
  localparam logic [6:0] OFS_ROUTE_TERM12 = 7'h50;
  localparam logic [6:0] OFS_ROUTE_RELAY = 7'h54;

  // Control register fields
  localparam int OL_MODE_LSB = 0;
  localparam int TQ_MODE_LSB = 2;
  localparam int TQ_DIR_LSB = 4;
  localparam logic [1:0] MODE_ANY_RAMP = 2'h0;
  localparam logic [1:0] MODE_CONST_ONLY = 2'h1;
  localparam logic [1:0] TQ_SEL_OVER = 2'h0;
  localparam logic [1:0] TQ_SEL_UNDER = 2'h1;

  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0005;          // Overload and torque modes constant-only, over-torque
  localparam logic [15:0] RST_OL_LEVEL = 16'h0064;      // 0.01 x rated current units, 1.00 x rated
  localparam logic [15:0] RST_ARRIVAL = 16'h0000;       // 0.01 Hz units
  localparam logic [15:0] RST_PID_ERR = 16'h001e;       // 0.1 % units, 3.0 %
  localparam logic [15:0] RST_PULSE_SCALE = 16'h0064;   // 0.01 units, 1.00
  localparam logic [15:0] RST_FB_UPPER = 16'h03e8;      // 100.0 %
  localparam logic [15:0] RST_FB_LOWER = 16'h0000;      // 0.0 %
  localparam logic [15:0] RST_TQ_LEVEL = 16'h0064;      // 100 %
  localparam logic [15:0] RST_THERMAL_WARN = 16'h005a;  // 90 %
  localparam logic [15:0] RST_ZERO_SPEED = 16'h0000;    // 0.01 Hz units
  localparam logic [15:0] RST_HEATSINK_WARN = 16'h0064; // 100 degC
  localparam logic [15:0] RST_ROUTE = 16'h00ff;         // Terminal unused

  // Pulse scaling: one output pulse per unity of accumulated scale
  localparam logic [23:0] PULSE_UNITY = 24'h000064;

  // Flag positions in the status word
  localparam int FLAG_OL = 0;
  localparam int FLAG_ARR1 = 1;
  localparam int FLAG_ARR2 = 2;
  localparam int FLAG_PID_DEV = 3;
  localparam int FLAG_PID_SECOND = 4;
  localparam int FLAG_TORQUE = 5;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_THERMAL = 7;
  localparam int FLAG_HEATSINK = 8;
  localparam int NUM_FLAGS = 9;

  // Output terminal function codes
  localparam logic [7:0] FC_ARRIVAL_ONE = 8'h01;
  localparam logic [7:0] FC_ARRIVAL_TWO = 8'h02;
  localparam logic [7:0] FC_OVERLOAD = 8'h03;
  localparam logic [7:0] FC_PID_DEV = 8'h04;
  localparam logic [7:0] FC_TORQUE = 8'h07;
  localparam logic [7:0] FC_THERMAL = 8'h0d;
  localparam logic [7:0] FC_ZERO_SPEED = 8'h15;
  localparam logic [7:0] FC_HEATSINK = 8'h1c;
  localparam logic [7:0] FC_PID_SECOND = 8'h1f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [15:0] cfg_reset(input logic [6:0] ofs);
    logic [15:0] v;
    v = 16'h0000;
    case (ofs)
      OFS_CTRL: v = RST_CTRL;
      OFS_OL_LEVEL, OFS_OL_LEVEL_TWO: v = RST_OL_LEVEL;
      OFS_ACCEL_ARR, OFS_DECEL_ARR, OFS_ACCEL_ARR_TWO, OFS_DECEL_ARR_TWO: v = RST_ARRIVAL;
      OFS_PID_ERR: v = RST_PID_ERR;
      OFS_PULSE_SCALE: v = RST_PULSE_SCALE;
      OFS_FB_UPPER: v = RST_FB_UPPER;
      OFS_FB_LOWER: v = RST_FB_LOWER;
      OFS_TQ_FWD_POWER, OFS_TQ_REV_REGEN, OFS_TQ_REV_POWER, OFS_TQ_FWD_REGEN: v = RST_TQ_LEVEL;
      OFS_THERMAL_WARN: v = RST_THERMAL_WARN;
      OFS_ZERO_SPEED: v = RST_ZERO_SPEED;
      OFS_HEATSINK_WARN: v = RST_HEATSINK_WARN;
      OFS_ROUTE_TERM11, OFS_ROUTE_TERM12, OFS_ROUTE_RELAY: v = RST_ROUTE;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : cfg_reset

endpackage : dowf_pkg

// >>> dowf_term_reader.sv
// Purpose: Terminal reader standing in for equipment on the output terminals
// Assumes: Samples on core_clk like a synchronous input card
// Notes: Adds one cycle of delay, as an external latch would
`timescale 1ns/100ps
module dowf_term_reader (
  input wire logic core_clk,
  input wire logic [2:0] termOut,
  output logic [2:0] seenTerm
);
  always_ff @(posedge core_clk) begin
    seenTerm <= termOut;
  end
endmodule : dowf_term_reader

// >>> tb.sv
// Purpose: Self-checking bench for the drive warning flag block
// Assumes: CTRL_CYCLES cut to 4; AXI4-Lite master lives in tasks
// Notes: Waits of CT+3 cycles cover one tick, the terminal and the reader
`timescale 1ns/100ps
module tb;
  localparam int CT = 4;
  int err_count = 0;
  int cmp_count = 0;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rampAccel, rampDecel, motorTwoActive;
  logic runReverse, regenActive, vectorCtrlActive, pulseTrainPin, pulseOut, pidSecondStage;
  logic overloadWarningFlag, arrivalFlagOne, arrivalFlagTwo, pidDeviationFlag;
  logic torqueThresholdFlag, zeroSpeedFlag, thermalWarnFlag, heatsinkHotFlag;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] motorCurrent, outFreq, pidSetpoint, pidFeedback, thermalLoad, heatsinkTemp;
  logic signed [15:0] torqueEst;
  logic [2:0] termOut, seenTerm;
  dowf_warning_flags #(.CTRL_CYCLES(CT)) i_dowf_warning_flags (.*);
  dowf_term_reader i_dowf_term_reader (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Handshakes sampled at the falling edge, where combinational readies have settled
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge core_clk);
    s_axi_awaddr <= {25'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    logic ta, tr;
    @(posedge core_clk);
    s_axi_araddr <= {25'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic settle();
    repeat (CT + 3) @(posedge core_clk);
  endtask : settle
  task automatic t_reset_values();
    rd(dowf_pkg::OFS_CTRL);
    chk("ctrl", 32'h5, rv);
    rd(dowf_pkg::OFS_TQ_REV_POWER);
    chk("torque level", 32'h64, rv);
    rd(dowf_pkg::OFS_THERMAL_WARN);
    chk("thermal level", 32'h5a, rv);
    rd(7'h58);
    chk("unmapped", 32'h2, {30'h0, resp});
    wr(dowf_pkg::OFS_STATUS, 32'h1ff);
    chk("status write", 32'h2, {30'h0, resp});
  endtask : t_reset_values
  task automatic t_overload();
    wr(dowf_pkg::OFS_ROUTE_TERM11, {24'h0, dowf_pkg::FC_OVERLOAD});
    wr(dowf_pkg::OFS_OL_LEVEL, 32'h96);
    wr(dowf_pkg::OFS_OL_LEVEL_TWO, 32'h0);
    motorCurrent <= 16'h96;
    settle();
    chk("overload", 32'h1, {31'h0, seenTerm[0]});
    motorCurrent <= 16'h95;
    settle();
    chk("overload", 32'h0, {31'h0, overloadWarningFlag});
    motorCurrent <= 16'h96;
    rampAccel <= 1'b1;
    settle();
    chk("overload accel", 32'h0, {31'h0, overloadWarningFlag});
    rampAccel <= 1'b0;
    motorTwoActive <= 1'b1;
    settle();
    chk("overload off", 32'h0, {31'h0, overloadWarningFlag});
    motorTwoActive <= 1'b0;
    rampAccel <= 1'b1;
    wr(dowf_pkg::OFS_CTRL, 32'h4);
    settle();
    chk("overload any", 32'h1, {31'h0, overloadWarningFlag});
  endtask : t_overload
  task automatic t_zero_temps();
    wr(dowf_pkg::OFS_ROUTE_RELAY, {24'h0, dowf_pkg::FC_ZERO_SPEED});
    wr(dowf_pkg::OFS_ZERO_SPEED, 32'h1f4);
    outFreq <= 16'h1f3;
    heatsinkTemp <= 16'h64;
    thermalLoad <= 16'h5a;
    settle();
    chk("relay", 32'h1, {31'h0, seenTerm[2]});
    chk("heatsink", 32'h0, {31'h0, heatsinkHotFlag});
    chk("thermal", 32'h1, {31'h0, thermalWarnFlag});
    outFreq <= 16'h1f4;
    heatsinkTemp <= 16'h65;
    thermalLoad <= 16'h59;
    settle();
    chk("zero", 32'h0, {31'h0, zeroSpeedFlag});
    chk("heatsink", 32'h1, {31'h0, heatsinkHotFlag});
    chk("thermal", 32'h0, {31'h0, thermalWarnFlag});
  endtask : t_zero_temps
  task automatic t_pid_tq();
    wr(dowf_pkg::OFS_ROUTE_TERM12, {24'h0, dowf_pkg::FC_TORQUE});
    wr(dowf_pkg::OFS_CTRL, 32'h0);
    wr(dowf_pkg::OFS_ACCEL_ARR_TWO, 32'h1f5);
    {pidSetpoint, pidFeedback, torqueEst, vectorCtrlActive} <= {16'h1f4, 16'h3e9, 16'hff9b, 1'b1};
    settle();
    rd(dowf_pkg::OFS_STATUS);
    chk("status", 32'h12b, rv);
    chk("term12", 32'h1, {31'h0, seenTerm[1]});
    wr(dowf_pkg::OFS_CTRL, 32'h10);
    wr(dowf_pkg::OFS_FB_LOWER, 32'h258);
    wr(dowf_pkg::OFS_DECEL_ARR, 32'h1f5);
    {pidFeedback, torqueEst, runReverse, rampAccel, rampDecel} <= {16'h1f4, 16'h32, 3'h5};
    settle();
    rd(dowf_pkg::OFS_STATUS);
    chk("status", 32'h135, rv);
    {vectorCtrlActive, pulseTrainPin} <= 2'h1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("pulse", 32'h1, {31'h0, pulseOut});
    @(negedge core_clk);
    chk("pulse", 32'h0, {31'h0, pulseOut});
    settle();
    chk("term12", 32'h0, {31'h0, seenTerm[1]});
  endtask : t_pid_tq
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rst, s_axi_wstrb} = 5'h1f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rampAccel, rampDecel} = '0;
    {motorTwoActive, runReverse, regenActive, vectorCtrlActive, pulseTrainPin} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, motorCurrent, outFreq, pidSetpoint, pidFeedback} = '0;
    {thermalLoad, heatsinkTemp, torqueEst} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_values();
    t_overload();
    t_zero_temps();
    t_pid_tq();
    tally_and_finish();
  end
endmodule : tb
